// [logic/ssp_pipe_engine.sv]
/*
  Synchronous-link message pipe engine: strap capture, opcode decode,
  control queue, notification and measurement pipes, data-ready pin.
  Assumes a byte-level link front end on linkClk (framing done outside)
  and a message interpreter on clk that drains and fills the pipes.
*/
// Notes on behaviour
// - straps sampled once after reset, interface held until next reset
// - straps 11 I2C, 10 SPI, 01 half-duplex UART, 00 full-duplex UART
// - undriven straps read high, so I2C is the default
// - pipe layer active only on I2C or SPI; UART passes messages as-is
// - host is master; engine never starts a transfer, only answers
// - 1 to 64 data bytes of one control write form exactly one queued message unless the previous one still drains; past 64 only bytes after the last wrap queue
// - messages leave in order; responses read through notification pipe
// - mode messages switch modes; measurement pipe filled only when measuring
// - pipe status gives byte size of next pending message per pipe
// - data-ready active while a pipe holds a message, idle when all read
// - first byte of each transfer is the opcode, data bytes follow
// - opcodes 01 info, 02 config, 03 control, 04 status, 05 notif, 06 meas
// - pipe payloads are shortened messages without preamble and bus id
// - shortened message checksum still counts bus id as 0xff
// - info read returns version byte then configuration byte
// - config write carries one byte that replaces the configuration
// - bit 3 enables measurement events, bit 2 notification events
// - bit 1 selects push-pull (0) or open-drain (1)
// - bit 0 selects idle level, 0 idle low for write and readback
// - bits 7 to 4 reserved without function
// - status returns two 16-bit little-endian sizes, notification first
`timescale 1ns/100ps
module ssp_pipe_engine
  import ssp_pkg::*;
#(
  parameter logic [7:0] PROTO_VERSION = 8'h01,
  parameter logic [7:0] ENTER_CFG_MID = 8'ha0,
  parameter logic [7:0] ENTER_MEAS_MID = 8'ha1
)(
  // system
  input wire logic clk,
  input wire logic reset_n,
  // interface straps, asynchronous pins
  input wire logic ifaceSelectHighPin,
  input wire logic ifaceSelectLowPin,
  output logic [1:0] ifaceMode,
  output logic pipeLayerOn,
  // byte link, linkClk domain except linkSelect
  input wire logic linkClk,
  input wire logic linkSelect,
  input wire logic linkRxStrobe,
  input wire logic [7:0] linkRxByte,
  input wire logic linkTxTake,
  output logic [7:0] linkTxByte,
  // control messages towards the interpreter
  output logic ctlMsgValid,
  output logic [7:0] ctlMsgByte,
  output logic ctlMsgLast,
  input wire logic ctlMsgReady,
  // notification pipe fill
  input wire logic notifWrValid,
  input wire logic [7:0] notifWrByte,
  input wire logic notifWrLast,
  output logic notifWrReady,
  // measurement pipe fill
  input wire logic measWrValid,
  input wire logic [7:0] measWrByte,
  input wire logic measWrLast,
  output logic measWrReady,
  output logic measMode,
  // data-ready pin
  output logic dataReadyOut,
  output logic dataReadyOe
);

  // ----------------------------------------------------------------
  // link domain capture
  // ----------------------------------------------------------------
  // bytes are held quasi-static; the toggles tell clk that they changed
  logic [7:0] rxByteL_q;
  logic rxTogL_q;
  logic takeTogL_q;
  logic [7:0] txByteL_q;
  logic [7:0] txHold_q;

  always_ff @(posedge linkClk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxByteL_q <= 8'h00;
      rxTogL_q <= 1'b0;
      takeTogL_q <= 1'b0;
      txByteL_q <= 8'h00;
    end
    else
    begin
      if (linkRxStrobe)
      begin
        rxByteL_q <= linkRxByte;
        rxTogL_q <= ~rxTogL_q;
      end
      if (linkTxTake)
      begin
        txByteL_q <= txHold_q;
        takeTogL_q <= ~takeTogL_q;
      end
    end
  end

  assign linkTxByte = txByteL_q;

  // ----------------------------------------------------------------
  // synchronisers into clk
  // ----------------------------------------------------------------
  logic [1:0] selS1_q, selS2_q;
  logic [2:0] rxTogS_q, takeTogS_q, frameS_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      selS1_q <= SEL_PULLUP;
      selS2_q <= SEL_PULLUP;
      rxTogS_q <= 3'h0;
      takeTogS_q <= 3'h0;
      frameS_q <= 3'h0;
    end
    else
    begin
      selS1_q <= {ifaceSelectHighPin, ifaceSelectLowPin};
      selS2_q <= selS1_q;
      rxTogS_q <= {rxTogS_q[1:0], rxTogL_q};
      takeTogS_q <= {takeTogS_q[1:0], takeTogL_q};
      frameS_q <= {frameS_q[1:0], linkSelect};
    end
  end

  wire rxEvt = rxTogS_q[2] ^ rxTogS_q[1];
  wire takeEvt = takeTogS_q[2] ^ takeTogS_q[1];
  wire frameStart = frameS_q[1] & ~frameS_q[2];
  wire frameEndRaw = ~frameS_q[1] & frameS_q[2];
  // rxByteL_q is stable by the time its toggle is seen two stages later
  wire [7:0] rxByte = rxByteL_q;

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  logic [1:0] strapCnt_q;
  logic strapDone_q;
  logic [1:0] ifaceMode_q;
  logic pipeOn_q;

  // straps taken once the synchroniser has filled, then frozen
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strapCnt_q <= 2'h0;
      strapDone_q <= 1'b0;
      ifaceMode_q <= SEL_PULLUP;
      pipeOn_q <= 1'b0;
    end
    else if (!strapDone_q)
    begin
      strapCnt_q <= strapCnt_q + 2'h1;
      if (strapCnt_q == STRAP_SETTLE)
      begin
        strapDone_q <= 1'b1;
        ifaceMode_q <= selS2_q;
        pipeOn_q <= (selS2_q == SEL_I2C) || (selS2_q == SEL_SPI);
      end
    end
  end

  assign ifaceMode = ifaceMode_q;
  assign pipeLayerOn = pipeOn_q;

  // ----------------------------------------------------------------
  // transfer engine
  // ----------------------------------------------------------------
  ssp_state_e st_q;
  logic [7:0] curOp_q;
  logic [LEN_W-1:0] rxCnt_q;
  logic [LEN_W-1:0] txIdx_q;
  logic readAll_q;
  logic [1:0] endDly_q;
  logic [7:0] cfg_q;
  logic [7:0] ctlFirst_q;
  logic [7:0] ctlBuf [PIPE_DEPTH];
  logic ctlBusy_q;
  logic [LEN_W-1:0] ctlLen_q;
  logic measMode_q;
  logic [1:0] popReq;
  logic [LEN_W-1:0] pipeLen [2];

  function automatic logic opKnown(input logic [7:0] op);
    opKnown = (op >= OP_INFO) && (op <= OP_MEAS);
  endfunction

  function automatic logic [LEN_W-1:0] readLen(input logic [7:0] op,
    input logic [LEN_W-1:0] nLen, input logic [LEN_W-1:0] mLen);
    case (op)
      OP_INFO: readLen = INFO_LEN;
      OP_STATUS: readLen = STATUS_LEN;
      OP_NOTIF: readLen = nLen;
      OP_MEAS: readLen = mLen;
      default: readLen = 7'h00;
    endcase
  endfunction

  // frame end lags so the last byte toggle is always seen first
  wire frameEnd = endDly_q[1];
  wire opcodeByte = (st_q == ST_OPCODE) && rxEvt;
  wire dataByte = (st_q == ST_DATA) && rxEvt;
  // a control write while the previous message is still draining is dropped
  wire opAccept = opKnown(rxByte) && !(rxByte == OP_CTL && ctlBusy_q);
  wire [LEN_W-1:0] curReadLen = readLen(curOp_q, pipeLen[0], pipeLen[1]);
  wire [LEN_W-1:0] txIdxInc = txIdx_q + 7'h01;
  wire txWrap = (txIdxInc >= curReadLen);
  wire ctlWrap = (rxCnt_q == LEN_FULL);
  wire [IDX_W-1:0] ctlPos = ctlWrap ? 6'h00 : rxCnt_q[IDX_W-1:0];
  wire closeCtl = (st_q == ST_CLOSE) && (curOp_q == OP_CTL) && (rxCnt_q != 7'h00);
  assign popReq[0] = (st_q == ST_CLOSE) && (curOp_q == OP_NOTIF) && readAll_q;
  assign popReq[1] = (st_q == ST_CLOSE) && (curOp_q == OP_MEAS) && readAll_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= ST_IDLE;
      curOp_q <= OP_NONE;
      rxCnt_q <= 7'h00;
      txIdx_q <= 7'h00;
      readAll_q <= 1'b0;
      endDly_q <= END_DELAY_INIT;
      cfg_q <= CFG_RESET;
      ctlFirst_q <= 8'h00;
    end
    else
    begin
      endDly_q <= {endDly_q[0], frameEndRaw};
      case (st_q)
        ST_IDLE:
        begin
          // the engine only ever answers a frame the host opened
          if (frameStart && pipeOn_q)
          begin
            st_q <= ST_OPCODE;
            rxCnt_q <= 7'h00;
            txIdx_q <= 7'h00;
            readAll_q <= 1'b0;
          end
        end
        ST_OPCODE:
        begin
          if (frameEnd)
            st_q <= ST_CLOSE;
          else if (opcodeByte)
          begin
            st_q <= ST_DATA;
            curOp_q <= opAccept ? rxByte : OP_NONE;
          end
        end
        ST_DATA:
        begin
          if (frameEnd)
            st_q <= ST_CLOSE;
          else if (dataByte)
          begin
            if (curOp_q == OP_CFG && rxCnt_q == 7'h00)
              cfg_q <= rxByte & CFG_USED_MASK;
            if (curOp_q == OP_CTL && rxCnt_q == 7'h00)
              ctlFirst_q <= rxByte;
            // oversize control writes restart the buffer with the excess
            rxCnt_q <= ctlWrap ? 7'h01 : rxCnt_q + 7'h01;
          end
        end
        ST_CLOSE:
          st_q <= ST_IDLE;
        default:
          st_q <= ST_IDLE;
      endcase
      // read data restarts from the start once the host reads past the end
      if (takeEvt && st_q != ST_IDLE)
      begin
        txIdx_q <= txWrap ? 7'h00 : txIdxInc;
        if (txWrap)
          readAll_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (dataByte && curOp_q == OP_CTL)
      ctlBuf[ctlPos] <= rxByte;
  end

  // ----------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------
  logic [7:0] txSel;
  always_comb
  begin
    case (curOp_q)
      OP_INFO: txSel = (txIdx_q == 7'h00) ? PROTO_VERSION : cfg_q;
      OP_STATUS:
      begin
        case (txIdx_q[1:0])
          2'h0: txSel = {1'b0, pipeLen[0]};
          2'h2: txSel = {1'b0, pipeLen[1]};
          default: txSel = 8'h00;
        endcase
      end
      OP_NOTIF: txSel = g_pipe[0].mem[txIdx_q[IDX_W-1:0]];
      OP_MEAS: txSel = g_pipe[1].mem[txIdx_q[IDX_W-1:0]];
      default: txSel = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      txHold_q <= 8'h00;
    else
      txHold_q <= txSel;
  end

  // ----------------------------------------------------------------
  // control queue drain and mode tracking
  // ----------------------------------------------------------------
  logic [LEN_W-1:0] ctlRdIdx_q;
  logic ctlValid_q, ctlLast_q;
  logic [7:0] ctlByte_q;
  // next mode, so the measurement pipe shuts in the same cycle as the mode
  wire measModeD = !closeCtl ? measMode_q :
                   (ctlFirst_q == ENTER_MEAS_MID) ? 1'b1 :
                   (ctlFirst_q == ENTER_CFG_MID) ? 1'b0 : measMode_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctlBusy_q <= 1'b0;
      ctlLen_q <= 7'h00;
      ctlRdIdx_q <= 7'h00;
      ctlValid_q <= 1'b0;
      ctlLast_q <= 1'b0;
      ctlByte_q <= 8'h00;
      measMode_q <= 1'b0;
    end
    else
    begin
      measMode_q <= measModeD;
      if (closeCtl)
      begin
        ctlBusy_q <= 1'b1;
        ctlLen_q <= rxCnt_q;
        ctlRdIdx_q <= 7'h00;
      end
      else if (ctlBusy_q && !ctlValid_q)
      begin
        // bytes pass unchanged, checksum included
        ctlByte_q <= ctlBuf[ctlRdIdx_q[IDX_W-1:0]];
        ctlLast_q <= (ctlRdIdx_q + 7'h01 == ctlLen_q);
        ctlValid_q <= 1'b1;
        ctlRdIdx_q <= ctlRdIdx_q + 7'h01;
      end
      else if (ctlValid_q && ctlMsgReady)
      begin
        ctlValid_q <= 1'b0;
        if (ctlLast_q)
          ctlBusy_q <= 1'b0;
      end
    end
  end

  assign ctlMsgValid = ctlValid_q;
  assign ctlMsgByte = ctlByte_q;
  assign ctlMsgLast = ctlLast_q;
  assign measMode = measMode_q;

  // ----------------------------------------------------------------
  // read pipes: one pending message each
  // ----------------------------------------------------------------
  // one message per pipe keeps storage small; the writer stalls until read
  wire [1:0] wrValid = {measWrValid, notifWrValid};
  wire [7:0] wrByte [2];
  wire [1:0] wrLast = {measWrLast, notifWrLast};
  wire [1:0] wrGate = {measModeD, 1'b1};
  assign wrByte[0] = notifWrByte;
  assign wrByte[1] = measWrByte;

  for (genvar p = 0; p < 2; p++)
  begin : g_pipe
    logic [7:0] mem [PIPE_DEPTH];
    logic [LEN_W-1:0] len_q, cnt_q;
    logic rdy_q;
    wire take = wrValid[p] && rdy_q;
    wire endMsg = take && (wrLast[p] || cnt_q == LEN_FULL - 7'h01);
    wire [LEN_W-1:0] lenD = popReq[p] ? 7'h00 : (endMsg ? cnt_q + 7'h01 : len_q);

    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        len_q <= 7'h00;
        cnt_q <= 7'h00;
        rdy_q <= 1'b0;
      end
      else
      begin
        len_q <= lenD;
        cnt_q <= endMsg ? 7'h00 : (take ? cnt_q + 7'h01 : cnt_q);
        rdy_q <= (lenD == 7'h00) && !endMsg && wrGate[p];
      end
    end

    always_ff @(posedge clk)
    begin
      if (take)
        mem[cnt_q[IDX_W-1:0]] <= wrByte[p];
    end

    assign pipeLen[p] = len_q;
  end

  assign notifWrReady = g_pipe[0].rdy_q;
  assign measWrReady = g_pipe[1].rdy_q;

  // ----------------------------------------------------------------
  // data-ready pin
  // ----------------------------------------------------------------
  wire pending = (cfg_q[CFG_NOTIF_EVT] && pipeLen[0] != 7'h00) ||
                 (cfg_q[CFG_MEAS_EVT] && pipeLen[1] != 7'h00);
  wire drLevel = pending ^ cfg_q[CFG_IDLE_LVL];
  logic drOut_q, drOe_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      drOut_q <= 1'b0;
      drOe_q <= 1'b1;
    end
    else
    begin
      drOut_q <= cfg_q[CFG_DRIVER] ? 1'b0 : drLevel;
      drOe_q <= cfg_q[CFG_DRIVER] ? !drLevel : 1'b1;
    end
  end

  assign dataReadyOut = drOut_q;
  assign dataReadyOe = drOe_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_close_ctl;
    closeCtl && !ctlBusy_q;
  endsequence
  sequence s_drain_start;
    ctlBusy_q ##1 ctlValid_q;
  endsequence

  a_strap_held: assert property (strapDone_q |=> $stable(ifaceMode_q))
    else $error("interface mode changed after capture");
  a_cfg_write: assert property (dataByte && curOp_q == OP_CFG && rxCnt_q == 7'h00
    |=> cfg_q == ($past(rxByte) & CFG_USED_MASK))
    else $error("config write not applied");
  a_reserved_zero: assert property (cfg_q[7:4] == 4'h0)
    else $error("reserved config bits set");
  a_bad_opcode: assert property (opcodeByte && !opKnown(rxByte)
    |=> curOp_q == OP_NONE && $stable(cfg_q))
    else $error("unknown opcode not ignored");
  a_ctl_enqueue: assert property (s_close_ctl |=> s_drain_start)
    else $error("control message not queued");
  a_meas_gate: assert property (measWrReady |-> measMode_q)
    else $error("measurement pipe open outside measurement mode");
  a_info_bytes: assert property (curOp_q == OP_INFO && txIdx_q == 7'h01 && $stable(cfg_q)
    |=> txHold_q == $past(cfg_q))
    else $error("info byte one is not the config");
  a_status_low: assert property (curOp_q == OP_STATUS && txIdx_q == 7'h02
    && $stable(curOp_q) |=> txHold_q == {1'b0, $past(pipeLen[1])})
    else $error("status measurement size wrong");
  a_pipe_pop: assert property (popReq[0] |=> pipeLen[0] == 7'h00)
    else $error("notification message not removed after read");
  a_ready_line: assert property (!cfg_q[CFG_DRIVER] && $stable(cfg_q)
    |=> drOe_q && drOut_q == $past(drLevel))
    else $error("push-pull data-ready level wrong");
  a_open_drain: assert property (cfg_q[CFG_DRIVER] |=> !drOut_q)
    else $error("open-drain pin drove high");

endmodule

// [logic/ssp_pkg.sv]
/*
  Constants shared by the synchronous pipe layer: opcodes, strap encodings,
  data-ready configuration layout, pipe sizes and engine states.
  Assumes byte-wide link traffic and one message per pipe at a time.
*/
package ssp_pkg;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_NONE = 8'h00;
  localparam logic [7:0] OP_INFO = 8'h01;
  localparam logic [7:0] OP_CFG = 8'h02;
  localparam logic [7:0] OP_CTL = 8'h03;
  localparam logic [7:0] OP_STATUS = 8'h04;
  localparam logic [7:0] OP_NOTIF = 8'h05;
  localparam logic [7:0] OP_MEAS = 8'h06;

  // ----------------------------------------------------------------
  // interface straps {high pin, low pin}
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_I2C = 2'h3;
  localparam logic [1:0] SEL_SPI = 2'h2;
  localparam logic [1:0] SEL_UART_HALF = 2'h1;
  localparam logic [1:0] SEL_UART_FULL = 2'h0;
  localparam logic [1:0] SEL_PULLUP = 2'h3;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ----------------------------------------------------------------
  // data-ready configuration byte
  // ----------------------------------------------------------------
  localparam int CFG_MEAS_EVT = 3;
  localparam int CFG_NOTIF_EVT = 2;
  localparam int CFG_DRIVER = 1;
  localparam int CFG_IDLE_LVL = 0;
  localparam logic [7:0] CFG_USED_MASK = 8'h0f;
  localparam logic [7:0] CFG_RESET = 8'h0c;

  // ----------------------------------------------------------------
  // sizes, counts, identity values
  // ----------------------------------------------------------------
  localparam int PIPE_DEPTH = 64;
  localparam int IDX_W = 6;
  localparam int LEN_W = 7;
  localparam logic [LEN_W-1:0] LEN_FULL = 7'h40;
  localparam logic [LEN_W-1:0] INFO_LEN = 7'h02;
  localparam logic [LEN_W-1:0] STATUS_LEN = 7'h04;
  localparam logic [1:0] END_DELAY_INIT = 2'h0;

  // ----------------------------------------------------------------
  // engine states, gray along idle-opcode-data-close
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_OPCODE = 2'h1,
    ST_DATA = 2'h3,
    ST_CLOSE = 2'h2
  } ssp_state_e;

endpackage

// [test/ssp_host_model.sv]
/*
  Host-side master model of the byte link: opens frames, sends the opcode
  and data bytes, takes read bytes.
  Assumes the engine samples the link on rising linkClk.
*/
`timescale 1ns/100ps
module ssp_host_model (
  // link towards the engine
  output logic linkClk,
  output logic linkSelect,
  output logic linkRxStrobe,
  output logic [7:0] linkRxByte,
  output logic linkTxTake,
  input wire logic [7:0] linkTxByte
);
  logic run;

  initial
  begin
    run = 1'b0;
    linkClk = 1'b0;
    linkSelect = 1'b0;
    linkRxStrobe = 1'b0;
    linkRxByte = 8'h00;
    linkTxTake = 1'b0;
  end

  // link clock stands low between frames
  always #7.5 linkClk = run ? ~linkClk : 1'b0;

  // only the host ever opens a frame
  task automatic xfer(input logic [7:0] tx[$], input int nRd, output logic [7:0] rx[$]);
    rx = {};
    run = 1'b1;
    @(posedge linkClk);
    linkSelect <= 1'b1;
    repeat (24) @(posedge linkClk);
    foreach (tx[k])
    begin
      linkRxStrobe <= 1'b1;
      linkRxByte <= tx[k];
      @(posedge linkClk);
      linkRxStrobe <= 1'b0;
      linkRxByte <= ~tx[k];
      repeat (15) @(posedge linkClk);
    end
    for (int k = 0; k < nRd; k++)
    begin
      linkTxTake <= 1'b1;
      @(posedge linkClk);
      linkTxTake <= 1'b0;
      @(posedge linkClk);
      rx.push_back(linkTxByte);
      repeat (14) @(posedge linkClk);
    end
    linkSelect <= 1'b0;
    repeat (4) @(posedge linkClk);
    run = 1'b0;
    #400;
  endtask
endmodule

// [test/ssp_pipe_engine_tb_top.sv]
/*
  Testbench of the pipe engine: host model on the link, bench as interpreter
  and pipe filler, queue reference of pipes, configuration and control.
  Assumes the package, engine and host model are compiled first.
*/
`timescale 1ns/100ps
`define CHK(nm, e, s) \
  begin n_tests++; if ((s) !== (e)) begin err_count++; \
  $display("mismatch %s exp %h got %h", nm, e, s); end end
module ssp_pipe_engine_tb_top
  import ssp_pkg::*;
;
  localparam logic [7:0] CFG_ID = 8'ha0;
  localparam logic [7:0] MEAS_ID = 8'ha1;
  logic clk = 1'b0, reset_n = 1'b0, selHi = 1'b1, selLo = 1'b1, ctlMsgReady = 1'b0;
  logic notifWrValid = 1'b0, notifWrLast = 1'b0, measWrValid = 1'b0, measWrLast = 1'b0;
  logic [7:0] notifWrByte = 8'h00, measWrByte = 8'h00, linkRxByte, linkTxByte, ctlMsgByte;
  logic [1:0] ifaceMode;
  logic linkClk, linkSelect, linkRxStrobe, linkTxTake, pipeLayerOn, ctlMsgValid, ctlMsgLast;
  logic notifWrReady, measWrReady, measMode, dataReadyOut, dataReadyOe;
  logic [7:0] cfgM;
  logic [7:0] nQ[$], mQ[$], ctlGot[$], rx[$];
  logic ctlEnd[$];
  logic [7:0] badOp[3] = '{8'h00, 8'h07, 8'hff};
  int err_count = 0, n_tests = 0, cyc = 0;
  logic [31:0] seed = 32'h0000da78;

  ssp_pipe_engine #(.ENTER_CFG_MID(CFG_ID), .ENTER_MEAS_MID(MEAS_ID)) ssp_pipe_engine_i (
    .clk, .reset_n, .ifaceSelectHighPin(selHi), .ifaceSelectLowPin(selLo), .ifaceMode,
    .pipeLayerOn, .linkClk, .linkSelect, .linkRxStrobe, .linkRxByte, .linkTxTake,
    .linkTxByte, .ctlMsgValid, .ctlMsgByte, .ctlMsgLast, .ctlMsgReady, .notifWrValid,
    .notifWrByte, .notifWrLast, .notifWrReady, .measWrValid, .measWrByte, .measWrLast,
    .measWrReady, .measMode, .dataReadyOut, .dataReadyOe);
  ssp_host_model ssp_host_model_i (.linkClk, .linkSelect, .linkRxStrobe, .linkRxByte,
    .linkTxTake, .linkTxByte);

  always #25 clk = ~clk;

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  // ----------------------------------------------------------------
  // interpreter side: stalls at random, ceiling on run length
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    ctlMsgReady <= rnd() > 8'h60;
    if (ctlMsgValid && ctlMsgReady)
    begin
      ctlGot.push_back(ctlMsgByte);
      ctlEnd.push_back(ctlMsgLast);
    end
    if (cyc > 40000)
    begin
      err_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic doReset(input logic [1:0] s);
    @(posedge clk);
    reset_n <= 1'b0;
    {selHi, selLo} <= s;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    cfgM = CFG_RESET;
    nQ.delete();
    mQ.delete();
    repeat (8) @(posedge clk);
  endtask

  task automatic chkRdy();
    logic lvl;
    repeat (8) @(posedge clk);
    lvl = ((cfgM[2] && nQ.size() > 0) || (cfgM[3] && mQ.size() > 0)) ^ cfgM[0];
    if (cfgM[1])
    begin
      `CHK("dataReadyOut", 1'b0, dataReadyOut)
      `CHK("dataReadyOe", !lvl, dataReadyOe)
    end
    else
    begin
      `CHK("dataReadyOut", lvl, dataReadyOut)
      `CHK("dataReadyOe", 1'b1, dataReadyOe)
    end
  endtask

  task automatic info();
    ssp_host_model_i.xfer({OP_INFO}, 2, rx);
    `CHK("version", 8'h01, rx[0])
    `CHK("config", cfgM, rx[1])
  endtask

  task automatic status();
    ssp_host_model_i.xfer({OP_STATUS}, 4, rx);
    `CHK("notifSize", 16'(nQ.size()), {rx[1], rx[0]})
    `CHK("measSize", 16'(mQ.size()), {rx[3], rx[2]})
  endtask

  task automatic readPipe(input bit m);
    logic [7:0] q[$];
    if (m) q = mQ; else q = nQ;
    ssp_host_model_i.xfer({m ? OP_MEAS : OP_NOTIF}, q.size(), rx);
    foreach (q[k]) `CHK("pipeByte", q[k], rx[k])
    if (m) mQ.delete(); else nQ.delete();
  endtask

  task automatic ctlWrite(input logic [7:0] id, input int n);
    logic [7:0] q[$];
    int t;
    q = {OP_CTL, id};
    for (int k = 0; k < n; k++) q.push_back(rnd());
    ctlGot.delete();
    ctlEnd.delete();
    ssp_host_model_i.xfer(q, 0, rx);
    t = 0;
    while (ctlGot.size() < q.size() - 1 && t < 500)
    begin
      @(posedge clk);
      t++;
    end
    repeat (8) @(posedge clk);
    `CHK("ctlCount", q.size() - 1, ctlGot.size())
    for (int k = 1; k < q.size(); k++)
    begin
      `CHK("ctlByte", q[k], ctlGot[k-1])
      `CHK("ctlLast", k == q.size() - 1, ctlEnd[k-1])
    end
    `CHK("measMode", id == MEAS_ID, measMode)
  endtask

  // handshake lands on the rising edge after ready is seen high
  task automatic fill(input bit m, input int n);
    logic [7:0] b;
    int t;
    @(posedge clk);
    for (int k = 0; k < n; k++)
    begin
      b = rnd();
      if (m) mQ.push_back(b); else nQ.push_back(b);
      measWrValid <= m;
      notifWrValid <= !m;
      measWrByte <= b;
      notifWrByte <= b;
      measWrLast <= k == n - 1;
      notifWrLast <= k == n - 1;
      t = 0;
      @(negedge clk);
      while ((m ? measWrReady : notifWrReady) !== 1'b1 && t < 100)
      begin
        @(negedge clk);
        t++;
      end
      @(posedge clk);
    end
    measWrValid <= 1'b0;
    notifWrValid <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    for (int s = 0; s < 4; s++)
    begin
      doReset(2'(s));
      `CHK("ifaceMode", 2'(s), ifaceMode)
      `CHK("pipeLayerOn", s[1], pipeLayerOn)
      if (!s[1])
      begin
        ssp_host_model_i.xfer({OP_CTL, MEAS_ID, 8'h5a}, 0, rx);
        repeat (8) @(posedge clk);
        `CHK("uartCtlBytes", 0, ctlGot.size())
        `CHK("uartMeasMode", 1'b0, measMode)
      end
      {selHi, selLo} <= ~2'(s);
      repeat (10) @(posedge clk);
      `CHK("ifaceMode", 2'(s), ifaceMode)
    end
    doReset(2'h3);
    chkRdy();
    info();
    ctlWrite(MEAS_ID, 5);
    for (int i = 0; i < 8; i++)
    begin
      ssp_host_model_i.xfer({OP_CFG, (rnd() & 8'hf0) | 8'(i * 3 & 15)}, 0, rx);
      cfgM = 8'((i * 3) & 15);
      info();
      fill(1'b0, 2 + (rnd() & 8'h07));
      fill(1'b1, 1 + (rnd() & 8'h0f));
      chkRdy();
      status();
      readPipe(1'b0);
      chkRdy();
      readPipe(1'b1);
      chkRdy();
    end
    foreach (badOp[k])
    begin
      ssp_host_model_i.xfer({badOp[k], 8'h5a}, 0, rx);
      info();
      status();
    end
    ctlWrite(CFG_ID, 3);
    `CHK("measWrReady", 1'b0, measWrReady)
    fill(1'b0, 64);
    status();
    readPipe(1'b0);
    chkRdy();
    end_of_test();
  end
endmodule
